// ==== verilog/flash_host_pkg.sv ====
// Constants, command codes and timing for the parallel flash host controller
package flash_host_pkg;
  // Command port offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h5;
  // Control fields: opcode in [3:0], go on write
  localparam int CTRL_OP_LSB = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE_PIN = 1;
  localparam int STAT_ERR = 2;
  localparam int MODE_BYTE = 0;
  localparam logic [31:0] MODE_RESET = 32'h0;
  // Operations
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_RESET = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_SECT_ERASE = 4'h5;
  localparam logic [3:0] OP_IDENT = 4'h6;
  localparam logic [3:0] OP_QUERY = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;
  localparam logic [3:0] OP_RESUME = 4'h9;
  localparam logic [3:0] OP_CLEAR = 4'ha;
  // Command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // Unlock and query addresses
  localparam logic [11:0] UNLK_A_WORD = 12'h555;
  localparam logic [11:0] UNLK_B_WORD = 12'h2aa;
  localparam logic [11:0] UNLK_A_BYTE = 12'haaa;
  localparam logic [11:0] UNLK_B_BYTE = 12'h555;
  localparam logic [11:0] QUERY_WORD = 12'h055;
  localparam logic [11:0] QUERY_BYTE = 12'h0aa;
  // Bus timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_NS = 90;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_NS = 35;
  localparam int WPULSE_CYC = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_NS = 30;
  localparam int RECOV_CYC = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_PULSE_MIN_NS = 500;
  localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_AFTER_CLEAR_NS = 50;
  localparam int READ_AFTER_CLEAR_CYC =
    (READ_AFTER_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
endpackage

// ==== verilog/flash_cycle.sv ====
// One asynchronous flash bus cycle: read, write or clear pulse
`timescale 1ns/1ps
module flash_cycle
  import flash_host_pkg::*;
#(
  parameter int AW = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic byte_mode,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic [AW-1:0] fa,
  output logic [15:0] fq_o,
  output logic [15:0] fq_oe,
  input wire logic [15:0] fq_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic clr_n
);
  typedef enum {C_IDLE, C_ACT, C_RECOV} cyc_e;
  typedef struct packed {
    cyc_e st;
    logic [1:0] kind;
    logic [CNT_W-1:0] cnt;
    logic done;
    logic [15:0] rdata;
    logic [AW-1:0] fa;
    logic [15:0] fq_o;
    logic drive;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic clr_n;
  } cyc_s;
  cyc_s s_r, s_nxt;

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n - 1);
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      C_IDLE: begin
        if (start) begin
          s_nxt.kind = kind;
          s_nxt.fa = addr;
          s_nxt.fq_o = wdata;
          s_nxt.st = C_ACT;
          if (kind == 2'd0) begin
            s_nxt.ce_n = 1'b0;
            s_nxt.oe_n = 1'b0;
            s_nxt.cnt = cnt_of(ACCESS_CYC);
          end else if (kind == 2'd1) begin
            s_nxt.ce_n = 1'b0;
            s_nxt.we_n = 1'b0;
            s_nxt.drive = 1'b1;
            s_nxt.cnt = cnt_of(WPULSE_CYC);
          end else begin
            s_nxt.clr_n = 1'b0;
            s_nxt.cnt = cnt_of(CLEAR_PULSE_CYC);
          end
        end
      end
      C_ACT: begin
        if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end else begin
          if (s_r.kind == 2'd0) begin
            // byte mode: top line is address, low byte only
            s_nxt.rdata = byte_mode ? {8'h00, fq_i[7:0]} : fq_i;
          end
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.clr_n = 1'b1;
          s_nxt.st = C_RECOV;
          // wait before next read after clear
          s_nxt.cnt = (s_r.kind == 2'd2) ? cnt_of(READ_AFTER_CLEAR_CYC) : cnt_of(RECOV_CYC);
        end
      end
      C_RECOV: begin
        s_nxt.drive = 1'b0;
        if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end else begin
          s_nxt.st = C_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: C_IDLE, kind: 2'd0, cnt: '0, done: 1'b0, rdata: 16'h0000, fa: '0,
               fq_o: 16'h0000, drive: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
               clr_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.st != C_IDLE);
  assign done = s_r.done;
  assign rdata = s_r.rdata;
  assign fa = s_r.fa;
  assign fq_o = s_r.fq_o;
  // top line never driven as data in byte mode
  assign fq_oe = s_r.drive ? (byte_mode ? 16'h00ff : 16'hffff) : 16'h0000;
  assign ce_n = s_r.ce_n;
  assign oe_n = s_r.oe_n;
  assign we_n = s_r.we_n;
  assign clr_n = s_r.clr_n;
endmodule

// ==== verilog/flash_host.sv ====
// Host controller that sequences commands onto a parallel NOR flash bus
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int AW = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA_O,
  output logic [AW-1:0] FLASH_A,
  output logic [15:0] FLASH_Q_O,
  output logic [15:0] FLASH_Q_OE,
  input wire logic [15:0] FLASH_Q_I,
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic FLASH_CLEAR_N,
  output logic FLASH_BYTE_N,
  input wire logic DONE_FLAG_PIN
);
  import flash_host_pkg::*;

  typedef enum {H_IDLE, H_ISSUE, H_WAIT} host_e;
  typedef struct packed {
    host_e st;
    logic [3:0] op;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic byte_mode;
    logic err;
    logic [31:0] rd_out;
    logic go;
    logic [1:0] kind;
    logic [AW-1:0] cyc_addr;
    logic [15:0] cyc_data;
  } host_s;
  host_s s_r, s_nxt;

  logic cyc_busy, cyc_done;
  logic [15:0] cyc_rdata;

  // unlock address for the current width
  function automatic logic [AW-1:0] unlk(input logic first, input logic bm);
    logic [11:0] a;
    a = first ? (bm ? UNLK_A_BYTE : UNLK_A_WORD) : (bm ? UNLK_B_BYTE : UNLK_B_WORD);
    unlk = AW'(a);
  endfunction

  // Step table: returns {address, data} of cycle n of an operation
  function automatic logic [AW+15:0] step_of(input logic [3:0] op, input logic [2:0] n,
                                             input logic [AW-1:0] ua, input logic [15:0] ud,
                                             input logic bm);
    logic [7:0] c;
    step_of = {unlk(1'b1, bm), 16'h0000};
    c = 8'h00;
    case (n)
      3'd0: step_of = {unlk(1'b1, bm), 8'h00, CMD_UNLOCK1};
      3'd1: step_of = {unlk(1'b0, bm), 8'h00, CMD_UNLOCK2};
      3'd2: begin
        c = (op == OP_PROGRAM) ? CMD_PROGRAM : (op == OP_IDENT) ? CMD_IDENT : CMD_ERASE_SETUP;
        step_of = {unlk(1'b1, bm), 8'h00, c};
      end
      3'd3: begin
        if (op == OP_PROGRAM) step_of = {ua, ud};
        else step_of = {unlk(1'b1, bm), 8'h00, CMD_UNLOCK1};
      end
      3'd4: step_of = {unlk(1'b0, bm), 8'h00, CMD_UNLOCK2};
      default: begin
        // final erase code, sector location for sector erase
        if (op == OP_SECT_ERASE) step_of = {ua, 8'h00, CMD_SECT_ERASE};
        else step_of = {unlk(1'b1, bm), 8'h00, CMD_CHIP_ERASE};
      end
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.rd_out = 32'h0;
    if (REG_WR) begin
      if (REG_ADDR_I == REG_ADDR) begin
        s_nxt.addr = REG_WDATA_I[AW-1:0];
      end else if (REG_ADDR_I == REG_WDATA) begin
        s_nxt.wdata = REG_WDATA_I[15:0];
      end else if (REG_ADDR_I == REG_MODE && s_r.st == H_IDLE) begin
        s_nxt.byte_mode = REG_WDATA_I[MODE_BYTE];
      end else if (REG_ADDR_I == REG_CTRL && s_r.st == H_IDLE) begin
        s_nxt.op = REG_WDATA_I[CTRL_OP_LSB +: 4];
        s_nxt.step = 3'd0;
        s_nxt.err = 1'b0;
        s_nxt.st = H_ISSUE;
        case (REG_WDATA_I[CTRL_OP_LSB +: 4])
          OP_PROGRAM: s_nxt.nsteps = 3'd4;
          // identifier entry is three writes; a fourth unlock would leave the mode
          OP_IDENT: s_nxt.nsteps = 3'd3;
          OP_CHIP_ERASE, OP_SECT_ERASE: s_nxt.nsteps = 3'd6;
          OP_READ, OP_WRITE, OP_RESET, OP_QUERY, OP_SUSPEND, OP_RESUME, OP_CLEAR:
            s_nxt.nsteps = 3'd1;
          default: begin
            s_nxt.st = H_IDLE;
            s_nxt.err = 1'b1;
          end
        endcase
      end
    end
    if (REG_RD) begin
      if (REG_ADDR_I == REG_ADDR) s_nxt.rd_out = 32'(s_r.addr);
      else if (REG_ADDR_I == REG_WDATA) s_nxt.rd_out = {16'h0000, s_r.wdata};
      else if (REG_ADDR_I == REG_RDATA) s_nxt.rd_out = {16'h0000, s_r.rdata};
      else if (REG_ADDR_I == REG_MODE) s_nxt.rd_out = {31'h0, s_r.byte_mode};
      else if (REG_ADDR_I == REG_CTRL) s_nxt.rd_out = {28'h0, s_r.op};
      else if (REG_ADDR_I == REG_STATUS) begin
        s_nxt.rd_out[STAT_BUSY] = (s_r.st != H_IDLE) || cyc_busy;
        // done flag low means device still busy
        s_nxt.rd_out[STAT_DONE_PIN] = DONE_FLAG_PIN;
        s_nxt.rd_out[STAT_ERR] = s_r.err;
      end
    end
    case (s_r.st)
      H_ISSUE: begin
        s_nxt.go = 1'b1;
        s_nxt.kind = 2'd1;
        {s_nxt.cyc_addr, s_nxt.cyc_data} =
          step_of(s_r.op, s_r.step, s_r.addr, s_r.wdata, s_r.byte_mode);
        case (s_r.op)
          // plain array, identifier or query read
          OP_READ: begin
            s_nxt.kind = 2'd0;
            s_nxt.cyc_addr = s_r.addr;
          end
          OP_WRITE: {s_nxt.cyc_addr, s_nxt.cyc_data} = {s_r.addr, s_r.wdata};
          // reset code aborts failed operation or leaves identifier mode
          OP_RESET: s_nxt.cyc_data = {8'h00, CMD_RESET};
          // query entry, reads then repeat freely
          OP_QUERY: begin
            s_nxt.cyc_addr = AW'(s_r.byte_mode ? QUERY_BYTE : QUERY_WORD);
            s_nxt.cyc_data = {8'h00, CMD_QUERY};
          end
          // only useful during a sector erase
          OP_SUSPEND: s_nxt.cyc_data = {8'h00, CMD_SUSPEND};
          OP_RESUME: s_nxt.cyc_data = {8'h00, CMD_RESUME};
          OP_CLEAR: s_nxt.kind = 2'd2;
          default: ;
        endcase
        s_nxt.st = H_WAIT;
      end
      H_WAIT: begin
        if (cyc_done) begin
          if (s_r.op == OP_READ) s_nxt.rdata = cyc_rdata;
          if (s_r.step + 3'd1 >= s_r.nsteps) begin
            s_nxt.st = H_IDLE;
          end else begin
            s_nxt.step = s_r.step + 3'd1;
            s_nxt.st = H_ISSUE;
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '{st: H_IDLE, op: OP_READ, step: 3'd0, nsteps: 3'd1, addr: '0, wdata: 16'h0000,
               rdata: 16'h0000, byte_mode: MODE_RESET[MODE_BYTE], err: 1'b0, rd_out: 32'h0,
               go: 1'b0, kind: 2'd0, cyc_addr: '0, cyc_data: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  flash_cycle #(.AW(AW)) u_cycle (
    .clk(CLK),
    .rst(RST),
    .start(s_r.go),
    .kind(s_r.kind),
    .addr(s_r.cyc_addr),
    .wdata(s_r.cyc_data),
    .byte_mode(s_r.byte_mode),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fa(FLASH_A),
    .fq_o(FLASH_Q_O),
    .fq_oe(FLASH_Q_OE),
    .fq_i(FLASH_Q_I),
    .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N),
    .clr_n(FLASH_CLEAR_N)
  );

  assign REG_RDATA_O = s_r.rd_out;
  assign FLASH_BYTE_N = ~s_r.byte_mode;
endmodule

// ==== dv/flash_host_assertions.sv ====
// Bus pin checker for the flash host controller
`timescale 1ns/1ps
module flash_host_checker
  import flash_host_pkg::*;
#(
  parameter int AW = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [AW-1:0] FLASH_A,
  input wire logic [15:0] FLASH_Q_O,
  input wire logic [15:0] FLASH_Q_OE,
  input wire logic FLASH_CE_N,
  input wire logic FLASH_OE_N,
  input wire logic FLASH_WE_N,
  input wire logic FLASH_CLEAR_N,
  input wire logic FLASH_BYTE_N
);
  logic [7:0] clr_cnt_r;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Length of the clear pulse so far
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) clr_cnt_r <= 8'h0;
    else if (!FLASH_CLEAR_N) clr_cnt_r <= clr_cnt_r + 8'h1;
    else clr_cnt_r <= 8'h0;
  end
  chk_read_gate: assert property (
    !FLASH_OE_N |-> !FLASH_CE_N && FLASH_WE_N) else $error("read gate unselected");
  chk_no_contention: assert property (
    !FLASH_OE_N |-> FLASH_Q_OE == 16'h0) else $error("host drives in read");
  chk_write_gate: assert property (
    $fell(FLASH_WE_N) |-> !FLASH_CE_N && FLASH_OE_N && FLASH_Q_OE != 16'h0)
    else $error("write strobe unselected");
  chk_write_pulse: assert property (
    $fell(FLASH_WE_N) |-> !FLASH_WE_N [*5] ##1 FLASH_WE_N) else $error("write pulse length");
  chk_clear_quiet: assert property (
    !FLASH_CLEAR_N |-> FLASH_CE_N && FLASH_WE_N && FLASH_Q_OE == 16'h0)
    else $error("bus active in clear");
  chk_clear_len: assert property (
    $rose(FLASH_CLEAR_N) |-> clr_cnt_r >= CLEAR_PULSE_CYC) else $error("clear pulse short");
  chk_clear_wait: assert property (
    $rose(FLASH_CLEAR_N) |-> FLASH_OE_N [*7]) else $error("read too soon after clear");
  chk_unlock_addr: assert property (
    $fell(FLASH_WE_N) && FLASH_Q_O[7:0] == 8'h55 |->
    (FLASH_BYTE_N ? FLASH_A[10:0] == 11'h2aa : FLASH_A[11:0] == 12'h555))
    else $error("bad unlock address");
  chk_byte_lanes: assert property (
    !FLASH_BYTE_N && FLASH_Q_OE != 16'h0 |-> FLASH_Q_OE == 16'h00ff) else $error("byte lanes");
endmodule
bind flash_host flash_host_checker #(.AW(AW)) flash_host_checker_i (.CLK, .RST, .FLASH_A,
  .FLASH_Q_O, .FLASH_Q_OE, .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N, .FLASH_CLEAR_N, .FLASH_BYTE_N);

// ==== dv/flash_dev_model.sv ====
// Behavioural model of the parallel flash device
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int AW = 20,
  // Identifier values are arbitrary
  parameter logic [15:0] MAKER_ID = 16'h0001,
  parameter logic [15:0] DEVICE_ID = 16'h0002,
  // Odd figures keep the busy flag from changing on a clock edge
  parameter int PROG_NS = 401,
  parameter int ERASE_NS = 3001,
  parameter int RECOV_NS = 1001
) (
  input wire logic [AW-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic clear_n,
  input wire logic byte_n,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic done_flag
);
  typedef enum logic [3:0] {ARRAY, UNL1, UNL2, IDENT, QUERY, PROG, ESET, EUNL1, EUNL2} mode_e;
  mode_e st = ARRAY;
  logic [15:0] mem [0:4095];
  logic [15:0] v;
  logic flt = 1'b0;
  int gen = 0;
  // Chip select rises with the write strobe; a delayed copy avoids the race
  wire ce_dly;
  assign #1 ce_dly = ce_n;
  // Upper address bits play no part in the small array
  wire [10:0] u = byte_n ? addr[10:0] : addr[11:1];
  wire [AW-1:0] wa = byte_n ? addr : addr >> 1;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    done_flag = 1'b1;
  end
  // Released lines wander so a stale value never passes
  always #5 flt = ~flt;
  task automatic work(input int ns, input bit erase);
    int g;
    gen++;
    g = gen;
    done_flag = 1'b0;
    fork
      begin
        #ns;
        if (g == gen) begin
          if (erase) foreach (mem[i]) mem[i] = 16'hffff;
          done_flag = 1'b1;
        end
      end
    join_none
  endtask
  always @(posedge we_n) begin
    if (!ce_dly && clear_n && done_flag) begin
      case (st)
        UNL1: st = (u == 11'h2aa && din[7:0] == 8'h55) ? UNL2 : ARRAY;
        UNL2: st = u != 11'h555 ? ARRAY : din[7:0] == 8'h90 ? IDENT :
          din[7:0] == 8'ha0 ? PROG : din[7:0] == 8'h80 ? ESET : ARRAY;
        PROG: begin
          mem[wa[11:0]] = mem[wa[11:0]] & din;
          st = ARRAY;
          work(PROG_NS, 1'b0);
        end
        ESET: st = (u == 11'h555 && din[7:0] == 8'haa) ? EUNL1 : ARRAY;
        EUNL1: st = (u == 11'h2aa && din[7:0] == 8'h55) ? EUNL2 : ARRAY;
        EUNL2: begin
          if (din[7:0] == 8'h30 || (din[7:0] == 8'h10 && u == 11'h555)) work(ERASE_NS, 1'b1);
          st = ARRAY;
        end
        default: begin
          if (din[7:0] == 8'hf0) st = ARRAY;
          else if (u == 11'h555 && din[7:0] == 8'haa) st = UNL1;
          else if (u == 11'h055 && din[7:0] == 8'h98) st = QUERY;
        end
      endcase
    end
  end
  always @(negedge clear_n) begin
    st = ARRAY;
    if (!done_flag) begin
      gen++;
      fork
        #RECOV_NS done_flag = 1'b1;
      join_none
    end
  end
  always_comb begin
    case (st)
      IDENT: v = wa[1] ? 16'h0000 : wa[0] ? DEVICE_ID : MAKER_ID;
      QUERY: v = wa[7:0] == 8'h10 ? 16'h0051 : 16'h0000;
      default: v = mem[wa[11:0]];
    endcase
    if (ce_n || oe_n || !we_n || !clear_n) dout = {16{flt}};
    else if (!byte_n) dout = {{8{flt}}, addr[0] ? v[15:8] : v[7:0]};
    else dout = v;
  end
endmodule

// ==== dv/flash_host_bench.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module flash_host_bench;
  import flash_host_pkg::*;
  // Identifier values are arbitrary
  localparam logic [15:0] MAKER = 16'h003c;
  localparam logic [15:0] DEVID = 16'h1e77;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] rw = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdat;
  logic [19:0] fa;
  logic [15:0] qo, qoe, qi, dq;
  logic ce_n, oe_n, we_n, clr_n, byte_n, dfl;
  logic [31:0] v;
  int error_cnt = 0;
  int checked = 0;
  assign qi = (qo & qoe) | (dq & ~qoe);
  flash_host flash_host_i (.CLK(clk), .RST(rst), .REG_ADDR_I(ra), .REG_WDATA_I(rw),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA_O(rdat), .FLASH_A(fa), .FLASH_Q_O(qo),
    .FLASH_Q_OE(qoe), .FLASH_Q_I(qi), .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n),
    .FLASH_WE_N(we_n), .FLASH_CLEAR_N(clr_n), .FLASH_BYTE_N(byte_n), .DONE_FLAG_PIN(dfl));
  flash_dev_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID)) flash_dev_model_i (.addr(fa),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .clear_n(clr_n), .byte_n(byte_n), .din(qi),
    .dout(dq), .done_flag(dfl));
  initial forever #4 clk = ~clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rw <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
    wr(REG_ADDR, {12'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CTRL, {28'h0, o});
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS);
      if (v[STAT_BUSY] === 1'b0) break;
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS);
      if (v[STAT_DONE_PIN] === 1'b1) break;
    end
  endtask
  task automatic rdf(input logic [19:0] a);
    op(OP_READ, a, 16'h0);
    rd(REG_RDATA);
  endtask
  task automatic t_power_up();
    rdf(20'h00123);
    `CHK(v[15:0], 16'hffff)
    rd(4'hf);
    `CHK(v, 32'h0)
  endtask
  task automatic t_program();
    op(OP_PROGRAM, 20'h00123, 16'h1234);
    wait_ready();
    rdf(20'h80123);
    `CHK(v[15:0], 16'h1234)
  endtask
  task automatic t_ident();
    op(OP_IDENT, 20'h0, 16'h0);
    rdf(20'h00000);
    `CHK(v[15:0], MAKER)
    rdf(20'h40001);
    `CHK(v[15:0], DEVID)
    rdf(20'h00002);
    `CHK(v[7:0], 8'h00)
    rdf(20'h00000);
    `CHK(v[15:0], MAKER)
    op(OP_RESET, 20'h0, 16'h0);
    rdf(20'h00123);
    `CHK(v[15:0], 16'h1234)
  endtask
  task automatic t_query();
    op(OP_QUERY, 20'h0, 16'h0);
    for (int i = 0; i < 3; i++) begin
      rdf(20'h00010);
      `CHK(v[15:0], 16'h0051)
    end
    op(OP_RESET, 20'h0, 16'h0);
  endtask
  task automatic t_bad_seq();
    op(OP_WRITE, 20'h00555, 16'h00aa);
    op(OP_WRITE, 20'h00123, 16'h0077);
    rdf(20'h00123);
    `CHK(v[15:0], 16'h1234)
    op(OP_SUSPEND, 20'h0, 16'h0);
    op(OP_RESUME, 20'h0, 16'h0);
    rdf(20'h00123);
    `CHK(v[15:0], 16'h1234)
  endtask
  task automatic t_byte();
    wr(REG_MODE, 32'h1);
    @(posedge clk);
    #1;
    `CHK(byte_n, 1'b0)
    op(OP_IDENT, 20'h0, 16'h0);
    rdf(20'h00000);
    `CHK(v[7:0], MAKER[7:0])
    rdf(20'h00002);
    `CHK(v[7:0], DEVID[7:0])
    op(OP_RESET, 20'h0, 16'h0);
    wr(REG_MODE, 32'h0);
  endtask
  task automatic t_erase_clear();
    op(OP_SECT_ERASE, 20'h0, 16'h0);
    rd(REG_STATUS);
    `CHK(v[STAT_DONE_PIN], 1'b0)
    op(OP_CLEAR, 20'h0, 16'h0);
    rd(REG_STATUS);
    `CHK(v[STAT_DONE_PIN], 1'b0)
    wait_ready();
    rdf(20'h00123);
    `CHK(v[15:0], 16'h1234)
    // restart the cut-short erase; the reset in flight must not stop it
    op(OP_SECT_ERASE, 20'h0, 16'h0);
    op(OP_RESET, 20'h0, 16'h0);
    wait_ready();
    rdf(20'h00123);
    `CHK(v[15:0], 16'hffff)
  endtask
  task automatic t_chip_erase();
    op(OP_PROGRAM, 20'h00123, 16'h00aa);
    wait_ready();
    rdf(20'h00123);
    `CHK(v[15:0], 16'h00aa)
    op(OP_CHIP_ERASE, 20'h0, 16'h0);
    rd(REG_STATUS);
    `CHK(v[STAT_DONE_PIN], 1'b0)
    wait_ready();
    rdf(20'h00123);
    `CHK(v[15:0], 16'hffff)
    // Unknown opcode is refused without a bus cycle
    wr(REG_CTRL, 32'hf);
    rd(REG_STATUS);
    `CHK(v[STAT_ERR], 1'b1)
    `CHK(v[STAT_BUSY], 1'b0)
  endtask
  task automatic print_verdict();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_program();
    t_ident();
    t_query();
    t_bad_seq();
    t_byte();
    t_erase_clear();
    t_chip_erase();
    print_verdict();
  end
endmodule
